/* File: common/acsc_pkg.sv */
// Purpose: Constants, carriers and helpers of the analog and clock scan cells.
// Assumes: Chain holds controls at the low end, observe-only cells above them.
// Notes: Chain bit 0 is the cell nearest the test data output.
package acsc_pkg;
    localparam int DAC_W = 10;
    localparam int CTRL_W = 21;
    localparam int OBS_W = 5;
    localparam int CHAIN_LEN = CTRL_W + OBS_W;
    localparam int CTRL_LOW_W = 11;
    localparam int DAC_LSB = 11;
    localparam int STATUS_EXTEST_BIT = 5;
    localparam int MIN_ADDR_W = 4;
    localparam logic [3:0] FUNC_CTRL_OFFSET = 4'h0;
    localparam logic [3:0] FUNC_DAC_OFFSET = 4'h4;
    localparam logic [3:0] STATUS_OFFSET = 4'h8;

    typedef struct packed {
        logic [DAC_W-1:0] dac_value;
        logic amplifier_power_on;
        logic converter_power_on;
        logic converter_bandgap_enable;
        logic amp_path_enable;
        logic amp_clock;
        logic comparator_bandgap_enable;
        logic comparator_mux_select;
        logic comparator_off;
        logic slow_osc_enable;
        logic main_osc_enable;
        logic ext_clock_enable;
    } acsc_ctrl_type;

    typedef struct packed {
        logic converter_comp_result;
        logic comparator_result;
        logic slow_osc_clock_line;
        logic main_osc_clock_line;
        logic ext_clock_line;
    } acsc_obs_type;

    // Idle values: DAC top bit and comparator off set, all else clear
    localparam logic [CTRL_W-1:0] CTRL_IDLE = 21'h100008;

    // Forces the documented idle reading of each observed line
    function automatic acsc_obs_type acsc_gate_obs(input acsc_obs_type obs,
                                                    input acsc_ctrl_type ctrl);
        acsc_obs_type g;
        g.ext_clock_line = obs.ext_clock_line & ctrl.ext_clock_enable;
        g.main_osc_clock_line = obs.main_osc_clock_line | ~ctrl.main_osc_enable;
        g.slow_osc_clock_line = obs.slow_osc_clock_line | ~ctrl.slow_osc_enable;
        g.comparator_result = obs.comparator_result & ~ctrl.comparator_off;
        g.converter_comp_result = obs.converter_comp_result & ctrl.converter_power_on;
        return g;
    endfunction

    function automatic logic [31:0] acsc_be_merge(input logic [31:0] old_word,
                                                  input logic [31:0] new_word,
                                                  input logic [3:0] be);
        logic [31:0] m;
        for (int b = 0; b < 4; b++)
        begin
            m[b*8 +: 8] = be[b] ? new_word[b*8 +: 8] : old_word[b*8 +: 8];
        end
        return m;
    endfunction
endpackage

/* File: rtl/acsc_scan_cell.sv */
// Purpose: One boundary-scan cell, general or observe-only.
// Assumes: Capture, shift and update strobes are TAP state levels on TCK.
// Notes: Update acts on the rising edge of the update state, not the falling edge.
`timescale 1ns/100ps
`default_nettype none
module acsc_scan_cell #(
    parameter bit OBSERVE_ONLY = 1'b0,
    parameter bit IDLE_VALUE = 1'b0
) (
    input wire logic clk_tck_i,
    input wire logic test_logic_reset_i,
    input wire logic select_i,
    input wire logic capture_i,
    input wire logic shift_i,
    input wire logic update_i,
    input wire logic scan_in_i,
    input wire logic capture_value_i,
    output logic scan_out_o,
    output logic latch_o
);
    logic stage;
    logic latch;
    wire do_capture = select_i & capture_i;
    wire do_shift = select_i & shift_i & ~capture_i;
    wire do_update = select_i & update_i & ~OBSERVE_ONLY;
    wire next_stage = do_capture ? capture_value_i : (do_shift ? scan_in_i : stage);
    wire next_latch = do_update ? stage : latch;

    always_ff @(posedge clk_tck_i)
    begin
        if (test_logic_reset_i)
        begin
            stage <= IDLE_VALUE;
            latch <= IDLE_VALUE;
        end
        else
        begin
            stage <= next_stage;
            latch <= next_latch;
        end
    end

    assign scan_out_o = stage;
    assign latch_o = latch;
endmodule
`default_nettype wire

/* File: rtl/acsc_scan_top.sv */
// Purpose: Scan cells on the clock, comparator and converter analog boundary.
// Assumes: TAP controller and instruction decode run on TCK outside this block.
// Notes: Software sets the functional control values; extest replaces them.
`timescale 1ns/100ps
`default_nettype none
module acsc_scan_top #(
    parameter int ADDR_W = 4
) (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic [ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic clk_tck_i,
    input wire logic test_logic_reset_i,
    input wire logic chain_select_i,
    input wire logic capture_dr_i,
    input wire logic shift_dr_i,
    input wire logic update_dr_i,
    input wire logic extest_i,
    input wire logic tdi_i,
    output logic tdo_o,
    input wire acsc_pkg::acsc_obs_type analog_obs_i,
    output acsc_pkg::acsc_ctrl_type analog_ctrl_o
);
    if (ADDR_W < acsc_pkg::MIN_ADDR_W)
    begin : g_addr_check
        $error("Address too narrow for the register map");
    end

    // System domain: register slave
    logic ack;
    logic [31:0] readdata;
    acsc_pkg::acsc_ctrl_type func;
    acsc_pkg::acsc_ctrl_type analog_ctrl_q;
    acsc_pkg::acsc_ctrl_type latch_sys;
    acsc_pkg::acsc_obs_type obs_meta_s;
    acsc_pkg::acsc_obs_type obs_sys;
    logic extest_meta_s;
    logic extest_sys;
    logic tog_meta;
    logic tog_sync;
    logic tog_seen;
    logic upd_toggle;
    logic tlr_meta_s;
    logic tlr_sys;

    wire req = avs_read_i | avs_write_i;
    wire take_write = avs_write_i & ack;
    wire [3:0] addr_low = avs_address_i[3:0];
    wire upper_zero = (avs_address_i >> 4) == '0;
    wire sel_ctrl = upper_zero & (addr_low == acsc_pkg::FUNC_CTRL_OFFSET);
    wire sel_dac = upper_zero & (addr_low == acsc_pkg::FUNC_DAC_OFFSET);
    wire sel_status = upper_zero & (addr_low == acsc_pkg::STATUS_OFFSET);
    wire [31:0] ctrl_word = {21'h0, func[acsc_pkg::CTRL_LOW_W-1:0]};
    wire [31:0] dac_word = {22'h0, func.dac_value};
    wire acsc_pkg::acsc_obs_type status_obs = acsc_pkg::acsc_gate_obs(obs_sys, analog_ctrl_q);
    wire [31:0] status_word = {26'h0, extest_sys, status_obs};
    wire [31:0] ctrl_merged = acsc_pkg::acsc_be_merge(ctrl_word, avs_writedata_i,
                                                      avs_byteenable_i);
    wire [31:0] dac_merged = acsc_pkg::acsc_be_merge(dac_word, avs_writedata_i,
                                                     avs_byteenable_i);
    wire [31:0] rd_word = sel_ctrl ? ctrl_word :
                          sel_dac ? dac_word :
                          sel_status ? status_word : 32'h0;
    wire acsc_pkg::acsc_ctrl_type next_func =
        (take_write & sel_ctrl) ? {func.dac_value, ctrl_merged[acsc_pkg::CTRL_LOW_W-1:0]} :
        (take_write & sel_dac) ? {dac_merged[acsc_pkg::DAC_W-1:0],
                                  func[acsc_pkg::CTRL_LOW_W-1:0]} : func;
    wire upd_event = tog_sync ^ tog_seen;
    wire [acsc_pkg::CHAIN_LEN-1:0] latch_vec;
    wire acsc_pkg::acsc_ctrl_type next_analog_ctrl = extest_sys ? latch_sys : func;

    assign avs_waitrequest_o = req & ~ack;
    assign avs_readdata_o = readdata;
    assign analog_ctrl_o = analog_ctrl_q;

    always_ff @(posedge clk_sys_i)
    begin
        if (!resetn_i)
        begin
            ack <= 1'b0;
            readdata <= 32'h0;
            func <= acsc_pkg::CTRL_IDLE;
        end
        else
        begin
            ack <= req & ~ack;
            if (avs_read_i & ~ack)
            begin
                readdata <= rd_word;
            end
            func <= next_func;
        end
    end

    // Latched chain word is stable for many TCK cycles after the toggle flips
    always_ff @(posedge clk_sys_i)
    begin
        if (!resetn_i)
        begin
            obs_meta_s <= '0;
            obs_sys <= '0;
            extest_meta_s <= 1'b0;
            extest_sys <= 1'b0;
            tog_meta <= 1'b0;
            tog_sync <= 1'b0;
            tog_seen <= 1'b0;
            tlr_meta_s <= 1'b0;
            tlr_sys <= 1'b0;
            latch_sys <= acsc_pkg::CTRL_IDLE;
            analog_ctrl_q <= acsc_pkg::CTRL_IDLE;
        end
        else
        begin
            obs_meta_s <= analog_obs_i;
            obs_sys <= obs_meta_s;
            extest_meta_s <= extest_i;
            extest_sys <= extest_meta_s;
            tog_meta <= upd_toggle;
            tog_sync <= tog_meta;
            tog_seen <= tog_sync;
            tlr_meta_s <= test_logic_reset_i;
            tlr_sys <= tlr_meta_s;
            // Test reset may leave the toggle unchanged, so idle is forced here
            if (tlr_sys)
            begin
                latch_sys <= acsc_pkg::CTRL_IDLE;
            end
            else if (upd_event)
            begin
                latch_sys <= latch_vec[acsc_pkg::CTRL_W-1:0];
            end
            analog_ctrl_q <= next_analog_ctrl;
        end
    end

    // TCK domain: chain and crossings
    acsc_pkg::acsc_ctrl_type func_meta_t;
    acsc_pkg::acsc_ctrl_type func_tck;
    acsc_pkg::acsc_obs_type obs_meta_t;
    acsc_pkg::acsc_obs_type obs_tck;
    wire [acsc_pkg::CHAIN_LEN:0] so;
    wire acsc_pkg::acsc_ctrl_type applied_tck =
        extest_i ? latch_vec[acsc_pkg::CTRL_W-1:0] : func_tck;
    wire acsc_pkg::acsc_obs_type gated_tck = acsc_pkg::acsc_gate_obs(obs_tck, applied_tck);
    // Snapshot of a word may tear while software rewrites it
    wire [acsc_pkg::CHAIN_LEN-1:0] capture_vec = {gated_tck, func_tck};

    assign so[acsc_pkg::CHAIN_LEN] = tdi_i;
    assign tdo_o = so[0];

    always_ff @(posedge clk_tck_i)
    begin
        if (test_logic_reset_i)
        begin
            func_meta_t <= acsc_pkg::CTRL_IDLE;
            func_tck <= acsc_pkg::CTRL_IDLE;
            obs_meta_t <= '0;
            obs_tck <= '0;
            upd_toggle <= 1'b0;
        end
        else
        begin
            func_meta_t <= func;
            func_tck <= func_meta_t;
            obs_meta_t <= analog_obs_i;
            obs_tck <= obs_meta_t;
            upd_toggle <= upd_toggle ^ (chain_select_i & update_dr_i);
        end
    end

    for (genvar i = 0; i < acsc_pkg::CHAIN_LEN; i++)
    begin : g_cell
        acsc_scan_cell #(
            .OBSERVE_ONLY(i >= acsc_pkg::CTRL_W),
            .IDLE_VALUE(i < acsc_pkg::CTRL_W ? acsc_pkg::CTRL_IDLE[i % acsc_pkg::CTRL_W] : 1'b0)
        ) u_cell (
            .clk_tck_i(clk_tck_i),
            .test_logic_reset_i(test_logic_reset_i),
            .select_i(chain_select_i),
            .capture_i(capture_dr_i),
            .shift_i(shift_dr_i),
            .update_i(update_dr_i),
            .scan_in_i(so[i+1]),
            .capture_value_i(capture_vec[i]),
            .scan_out_o(so[i]),
            .latch_o(latch_vec[i])
        );
    end

    // Checks
    tdo_lsb_first_a: assert property (@(posedge clk_tck_i) disable iff (test_logic_reset_i)
        (chain_select_i & shift_dr_i & ~capture_dr_i) |=> (tdo_o == $past(so[1])))
        else $error("Chain did not shift toward the output");
    capture_clock_line_a: assert property (@(posedge clk_tck_i) disable iff (test_logic_reset_i)
        (chain_select_i & capture_dr_i) |=> (so[acsc_pkg::CTRL_W] == $past(gated_tck[0])))
        else $error("External clock line not captured");
    update_hold_a: assert property (@(posedge clk_tck_i) disable iff (test_logic_reset_i)
        !(chain_select_i & update_dr_i) |=> $stable(latch_vec))
        else $error("Latch moved outside update");
    reset_idle_a: assert property (@(posedge clk_tck_i)
        $past(test_logic_reset_i) |-> (latch_vec[acsc_pkg::CTRL_W-1:0] == acsc_pkg::CTRL_IDLE))
        else $error("Latches not at idle values after reset");
    ext_line_idle_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        !analog_ctrl_q.ext_clock_enable |-> !status_obs.ext_clock_line)
        else $error("Unused external clock line not zero");
    osc_line_idle_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        !(analog_ctrl_q.main_osc_enable & analog_ctrl_q.slow_osc_enable)
        |-> (status_obs.main_osc_clock_line | status_obs.slow_osc_clock_line))
        else $error("Unused oscillator line not one");
    comparator_idle_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        analog_ctrl_q.comparator_off |-> !status_obs.comparator_result)
        else $error("Idle comparator result not zero");
    converter_idle_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        !analog_ctrl_q.converter_power_on |-> !status_obs.converter_comp_result)
        else $error("Idle converter comparator not zero");
    extest_apply_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        (extest_sys & $past(extest_sys)) |-> (analog_ctrl_q == $past(latch_sys)))
        else $error("Extest did not drive latched values");
    latch_copy_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        upd_event |=> (latch_sys == $past(latch_vec[acsc_pkg::CTRL_W-1:0])))
        else $error("Updated latch word not taken over");
    bus_answer_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        req |-> ##[0:1] !avs_waitrequest_o)
        else $error("Bus answer later than one wait cycle");
endmodule
`default_nettype wire

/* File: verification/acsc_tap_model.sv */
// Purpose: Behavioural test controller driving the scan link on TCK.
// Assumes: Signals change on falling TCK; TCK stands low between frames.
// Notes: Three idle edges open each frame so the pin synchronisers settle.
`timescale 1ns/100ps
`default_nettype none
module acsc_tap_model (
    output logic clk_tck_o,
    output logic test_logic_reset_o,
    output logic chain_select_o,
    output logic capture_dr_o,
    output logic shift_dr_o,
    output logic update_dr_o,
    output logic extest_o,
    output logic tdi_o,
    input wire logic tdo_i
);
    initial
    begin
        {clk_tck_o, test_logic_reset_o, chain_select_o, capture_dr_o} = 4'h0;
        {shift_dr_o, update_dr_o, extest_o, tdi_o} = 4'h0;
    end
    task automatic tick();
        #80 clk_tck_o = 1'b1;
        #80 clk_tck_o = 1'b0;
    endtask
    task automatic reset_tap();
        test_logic_reset_o = 1'b1;
        repeat (3) tick();
        test_logic_reset_o = 1'b0;
        tick();
    endtask
    task automatic set_extest(input logic on);
        extest_o = on;
    endtask
    task automatic scan(input logic [25:0] din, output logic [25:0] dout);
        repeat (3) tick();
        chain_select_o = 1'b1;
        capture_dr_o = 1'b1;
        tick();
        capture_dr_o = 1'b0;
        shift_dr_o = 1'b1;
        for (int k = 0; k < 26; k++)
        begin
            dout[k] = tdo_i;
            tdi_o = din[k];
            tick();
        end
        shift_dr_o = 1'b0;
        update_dr_o = 1'b1;
        tick();
        update_dr_o = 1'b0;
        chain_select_o = 1'b0;
        // Released data line must not keep the last bit
        tdi_o = ~tdi_o;
        tick();
    endtask
endmodule
`default_nettype wire

/* File: verification/analog_clock_scan_cells_test.sv */
// Purpose: Register and scan-chain checks of the analog and clock cells.
// Assumes: Functional reset values equal the idle control values.
// Notes: Scan frames are run by the test controller model.
`timescale 1ns/100ps
`default_nettype none
module analog_clock_scan_cells_test;
    logic clk_sys_i = 1'b0;
    logic resetn_i = 1'b0;
    logic [3:0] avs_address_i = 4'h0;
    logic avs_read_i = 1'b0;
    logic avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0;
    logic [3:0] avs_byteenable_i = 4'hf;
    logic [31:0] avs_readdata_o;
    logic avs_waitrequest_o;
    logic clk_tck_i, test_logic_reset_i, chain_select_i, capture_dr_i;
    logic shift_dr_i, update_dr_i, extest_i, tdi_i, tdo_o;
    acsc_pkg::acsc_obs_type analog_obs_i = '0;
    acsc_pkg::acsc_ctrl_type analog_ctrl_o;
    logic [25:0] dout;
    int mismatches = 0;
    int n_tests = 0;
    int cycles = 0;
    always #4 clk_sys_i = ~clk_sys_i;
    acsc_scan_top u_dut (.clk_sys_i, .resetn_i, .avs_address_i, .avs_read_i, .avs_write_i,
        .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
        .clk_tck_i, .test_logic_reset_i, .chain_select_i, .capture_dr_i, .shift_dr_i,
        .update_dr_i, .extest_i, .tdi_i, .tdo_o, .analog_obs_i, .analog_ctrl_o);
    acsc_tap_model u_tap (.clk_tck_o(clk_tck_i), .test_logic_reset_o(test_logic_reset_i),
        .chain_select_o(chain_select_i), .capture_dr_o(capture_dr_i),
        .shift_dr_o(shift_dr_i), .update_dr_o(update_dr_i), .extest_o(extest_i),
        .tdi_o(tdi_i), .tdo_i(tdo_o));
    task automatic stop_test();
        if (mismatches == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // Answer taken in the wait-free cycle; release follows that edge
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                       input logic [3:0] be, output logic [31:0] q);
        @(posedge clk_sys_i);
        avs_address_i <= a;
        avs_read_i <= ~wr;
        avs_write_i <= wr;
        avs_writedata_i <= d;
        avs_byteenable_i <= be;
        @(posedge clk_sys_i);
        while (avs_waitrequest_o !== 1'b0)
            @(posedge clk_sys_i);
        q = avs_readdata_o;
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e, input string name);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, 4'hf, q);
        check(name, q, e);
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
        logic [31:0] q;
        bus(1'b1, a, d, be, q);
    endtask
    // Control output crosses from TCK, so its arrival is bounded, not fixed
    task automatic wait_ctrl(input logic [31:0] e);
        for (int i = 0; i < 40 && 32'(analog_ctrl_o) !== e; i++)
            @(posedge clk_sys_i);
    endtask
    always @(posedge clk_sys_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 30000)
        begin
            mismatches++;
            stop_test();
        end
    end
    initial
    begin
        fork
            begin
                repeat (4) @(posedge clk_sys_i);
                resetn_i <= 1'b1;
            end
            u_tap.reset_tap();
        join
        check("ctrl_reset", 32'(analog_ctrl_o), 32'(acsc_pkg::CTRL_IDLE));
        rd(4'h8, 32'h0000_0006, "status_idle_low");
        analog_obs_i <= 5'h1f;
        repeat (4) @(posedge clk_sys_i);
        rd(4'h8, 32'h0000_0006, "status_idle_high");
        rd(4'h0, 32'h0000_0008, "func_ctrl_reset");
        rd(4'h4, 32'h0000_0200, "func_dac_reset");
        wr(4'h0, 32'h0000_0001, 4'hf);
        wr(4'h4, 32'h0000_03ff, 4'h0);
        wr(4'hc, 32'hffff_ffff, 4'hf);
        repeat (2) @(posedge clk_sys_i);
        check("ctrl_func", 32'(analog_ctrl_o), 32'h0010_0001);
        rd(4'h4, 32'h0000_0200, "dac_no_lanes");
        rd(4'hc, 32'h0000_0000, "unmapped");
        rd(4'h8, 32'h0000_000f, "status_ext_on");
        u_tap.scan({5'h1f, 21'h0aa802}, dout);
        check("scan_capture", 32'(dout), 32'h01f0_0001);
        repeat (20) @(posedge clk_sys_i);
        check("ctrl_preload", 32'(analog_ctrl_o), 32'h0010_0001);
        u_tap.set_extest(1'b1);
        wait_ctrl(32'h000a_a802);
        check("ctrl_extest", 32'(analog_ctrl_o), 32'h000a_a802);
        rd(4'h8, 32'h0000_002e, "status_extest");
        analog_obs_i <= 5'h10;
        u_tap.scan({5'h00, 21'h0aa802}, dout);
        check("scan_extest", 32'(dout), 32'h0090_0001);
        u_tap.reset_tap();
        wait_ctrl(32'(acsc_pkg::CTRL_IDLE));
        check("ctrl_tap_reset", 32'(analog_ctrl_o), 32'(acsc_pkg::CTRL_IDLE));
        stop_test();
    end
endmodule
`default_nettype wire
